// ### lrc_regs.vh
`ifndef LRC_REGS_VH
`define LRC_REGS_VH

// picture geometry
`define LRC_ACTIVE_SAMPLES 9'h100
`define LRC_LINE_SAMPLES 9'h140
`define LRC_CODED_LINES 9'h08F
`define LRC_LAST_PIX 8'hFF
`define LRC_STORE_WORDS 17'h1_1E00
`define LRC_FIELD_BASE 17'h0_8F00

// timing: sample clock derived from the system clock
`define LRC_CLK_HZ 100000000
`define LRC_SAMPLE_HZ 5000000
`define LRC_SAMPLE_DIV (`LRC_CLK_HZ / `LRC_SAMPLE_HZ)
// last count of the sample divider, sample_div minus one
`define LRC_DIV_LAST 5'h13

// picture levels
`define LRC_BLACK 8'h10
`define LRC_WHITE 8'hEF
`define LRC_MID 8'h80

// movement threshold on |incoming - stored|
`define LRC_MOVE_THRESH 8'h06

// end-of-cluster word, and the pcm word length
`define LRC_EOC_CODE 10'h009
`define LRC_EOC_LEN 4'h4
`define LRC_PCM_LEN 4'h8

// word kinds towards the multiplex stage
`define LRC_KIND_PCM 2'h0
`define LRC_KIND_DPCM 2'h1
`define LRC_KIND_EOC 2'h2
`define LRC_KIND_REFRESH 2'h3

`endif

// ### lrc_vlc.v
`timescale 1ns/1ns
// quantizer and variable-length coder for one dpcm difference
module lrc_vlc (
	// difference, two's complement, -255..255
	input wire [8:0] diff,
	// quantized level, two's complement
	output reg [8:0] level,
	// code word right-justified, first bit sent is bit len-1
	output reg [9:0] code,
	output reg [3:0] len
);
	reg signed [8:0] d;
	reg [4:0] num;

	// 511 difference values onto sixteen levels, plain signed compare
	always @* begin
		d = diff;
		if (d <= -9'sd125) begin
			level = -9'sd141; num = 5'd17;
		end else if (d <= -9'sd95) begin
			level = -9'sd108; num = 5'd16;
		end else if (d <= -9'sd70) begin
			level = -9'sd81; num = 5'd15;
		end else if (d <= -9'sd49) begin
			level = -9'sd58; num = 5'd14;
		end else if (d <= -9'sd32) begin
			level = -9'sd39; num = 5'd13;
		end else if (d <= -9'sd19) begin
			level = -9'sd24; num = 5'd12;
		end else if (d <= -9'sd9) begin
			level = -9'sd13; num = 5'd10;
		end else if (d <= -9'sd1) begin
			level = -9'sd4; num = 5'd9;
		end else if (d <= 9'sd7) begin
			level = 9'sd3; num = 5'd1;
		end else if (d <= 9'sd17) begin
			level = 9'sd12; num = 5'd2;
		end else if (d <= 9'sd30) begin
			level = 9'sd23; num = 5'd3;
		end else if (d <= 9'sd47) begin
			level = 9'sd38; num = 5'd4;
		end else if (d <= 9'sd68) begin
			level = 9'sd57; num = 5'd5;
		end else if (d <= 9'sd93) begin
			level = 9'sd80; num = 5'd6;
		end else if (d <= 9'sd123) begin
			level = 9'sd107; num = 5'd7;
		end else begin
			level = 9'sd140; num = 5'd8;
		end
		// positive n: n zeros then 1; negative n: 1, n-9 zeros, 1
		if (num <= 5'd8) begin
			code = 10'h001;
			len = num[3:0] + 4'h1;
		end else begin
			code = (10'h002 << (num - 5'd9)) | 10'h001;
			len = num[3:0] - 4'h7;
		end
	end
endmodule // lrc_vlc

// ### lrc_coder.v
`timescale 1ns/1ns
`include "lrc_regs.vh"
module lrc_coder (
	// clock and reset
	input wire ref_clk,
	input wire arst_n,
	// video pins, asynchronous to ref_clk
	input wire [7:0] vid_data,
	input wire vid_hsync,
	input wire vid_vsync,
	input wire vid_field,
	input wire force_refresh,
	// coded word stream to the multiplex stage
	output wire out_valid,
	input wire out_ready,
	output wire [9:0] out_code,
	output wire [3:0] out_len,
	output wire [1:0] out_kind,
	output wire out_field,
	output wire [7:0] out_line,
	output wire [7:0] out_pix,
	output wire out_overrun
);
	localparam ST_IDLE = 2'b00;
	localparam ST_RDC = 2'b01;
	localparam ST_RDU = 2'b10;
	localparam ST_CODE = 2'b11;
	localparam [4:0] DIV_LAST = `LRC_DIV_LAST;

	// limit a value into the picture range
	function [7:0] lrc_clamp;
		input [9:0] v;
		begin
			if (v[9])
				lrc_clamp = `LRC_BLACK;
			else if (v[8:0] < {1'b0, `LRC_BLACK})
				lrc_clamp = `LRC_BLACK;
			else if (v[8:0] > {1'b0, `LRC_WHITE})
				lrc_clamp = `LRC_WHITE;
			else
				lrc_clamp = v[7:0];
		end
	endfunction

	reg [11:0] sync1_reg;
	reg [11:0] sync2_reg;
	reg hs_d_reg;
	reg vs_d_reg;
	reg [4:0] div_reg;
	reg [8:0] pix_reg;
	reg [9:0] in_line_reg;
	reg field_reg;
	reg refresh_reg;
	reg [7:0] lbuf [0:255];
	reg [7:0] mem [0:`LRC_STORE_WORDS-1];
	reg [7:0] mem_q;
	reg [16:0] mem_raddr;
	reg [1:0] st_reg;
	reg [7:0] x_reg;
	reg [7:0] s_reg;
	reg [7:0] job_pix_reg;
	reg [7:0] job_line_reg;
	reg job_field_reg;
	reg job_refresh_reg;
	reg [7:0] prev_rec_reg;
	reg in_cluster_reg;
	reg ov_valid_reg;
	reg [9:0] ov_code_reg;
	reg [3:0] ov_len_reg;
	reg [1:0] ov_kind_reg;
	reg ov_field_reg;
	reg [7:0] ov_line_reg;
	reg [7:0] ov_pix_reg;
	reg overrun_reg;
	reg word_en;
	reg [9:0] word_code;
	reg [3:0] word_len;
	reg [1:0] word_kind;
	reg store_en;
	reg [7:0] store_val;
	reg [7:0] held_val;
	reg cluster_next;

	wire [7:0] pin_data = sync2_reg[7:0];
	wire hs = sync2_reg[8];
	wire vs = sync2_reg[9];
	wire hs_rise = hs & ~hs_d_reg;
	wire vs_rise = vs & ~vs_d_reg;
	wire tick = (div_reg == DIV_LAST);
	wire active = tick && (pix_reg < `LRC_ACTIVE_SAMPLES);
	wire [8:0] coded_line = in_line_reg[9:1];
	wire pair_line = in_line_reg[0] && (coded_line < `LRC_CODED_LINES);
	wire start = active && pair_line && (st_reg == ST_IDLE);
	wire [8:0] pair_sum = {1'b0, lbuf[pix_reg[7:0]]} + {1'b0, pin_data};
	wire [16:0] base_addr = job_field_reg ? `LRC_FIELD_BASE : 17'h0_0000;
	wire [16:0] addr_cur = base_addr + {1'b0, job_line_reg, job_pix_reg};
	wire [16:0] addr_up = addr_cur - 17'h0_0100;
	wire load_ok = !ov_valid_reg || out_ready;

	// prediction neighbours and the dpcm path
	wire [7:0] a_val = (job_pix_reg == 8'h00) ? `LRC_MID : prev_rec_reg;
	wire up_blank = (job_line_reg == 8'h00) || (job_pix_reg == `LRC_LAST_PIX);
	wire [7:0] d_val = up_blank ? `LRC_MID : mem_q;
	wire [8:0] pred_sum = {1'b0, a_val} + {1'b0, d_val};
	wire [7:0] pred = pred_sum[8:1];
	wire [8:0] diff = {1'b0, x_reg} - {1'b0, pred};
	wire [8:0] q_level;
	wire [9:0] q_code;
	wire [3:0] q_len;
	wire [9:0] rec_sum = {2'b00, pred} + {q_level[8], q_level};
	wire [7:0] rec = lrc_clamp(rec_sum);
	wire [7:0] abs_move = (x_reg > s_reg) ? (x_reg - s_reg) : (s_reg - x_reg);
	wire moving = abs_move > `LRC_MOVE_THRESH;

	lrc_vlc u_vlc (
		.diff(diff),
		.level(q_level),
		.code(q_code),
		.len(q_len)
	);

	// two flip-flops on every video pin before use, third stage for sync edges
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 12'h000;
			sync2_reg <= 12'h000;
			hs_d_reg <= 1'b0;
			vs_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {force_refresh, vid_field, vid_vsync, vid_hsync, vid_data};
			sync2_reg <= sync1_reg;
			hs_d_reg <= hs;
			vs_d_reg <= vs;
		end
	end

	// sample enable divider, realigned at every line start
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			div_reg <= 5'h00;
		else if (hs_rise || tick)
			div_reg <= 5'h00;
		else
			div_reg <= div_reg + 5'h01;
	end

	// sample, line and field counters
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pix_reg <= 9'h000;
			in_line_reg <= 10'h000;
			field_reg <= 1'b0;
			refresh_reg <= 1'b0;
		end else begin
			if (hs_rise)
				pix_reg <= 9'h000;
			else if (tick && pix_reg != `LRC_LINE_SAMPLES - 9'h001)
				pix_reg <= pix_reg + 9'h001;
			if (vs_rise) begin
				in_line_reg <= 10'h000;
				field_reg <= sync2_reg[10];
			end else if (hs_rise) begin
				in_line_reg <= in_line_reg + 10'h001;
			end
			// refresh request is taken once per line pair
			if (hs_rise && in_line_reg[0])
				refresh_reg <= sync2_reg[11];
		end
	end

	// first line of each pair waits in the line buffer
	always @(posedge ref_clk) begin
		if (active && !in_line_reg[0])
			lbuf[pix_reg[7:0]] <= pin_data;
	end

	// frame store: one write and one registered read port
	always @* begin
		if (st_reg == ST_RDU)
			mem_raddr = addr_up;
		else
			mem_raddr = addr_cur;
	end

	always @(posedge ref_clk) begin
		if (store_en)
			mem[addr_cur] <= store_val;
		mem_q <= mem[mem_raddr];
	end

	// coding decision for the sample in hand
	always @* begin
		word_en = 1'b0;
		word_code = 10'h000;
		word_len = 4'h0;
		word_kind = `LRC_KIND_PCM;
		store_en = 1'b0;
		store_val = x_reg;
		held_val = s_reg;
		cluster_next = in_cluster_reg;
		if (st_reg == ST_CODE) begin
			if (job_refresh_reg) begin
				word_en = 1'b1;
				word_code = {2'b00, x_reg};
				word_len = `LRC_PCM_LEN;
				word_kind = `LRC_KIND_REFRESH;
				store_en = 1'b1;
				cluster_next = 1'b0;
			end else if (moving && !in_cluster_reg) begin
				word_en = 1'b1;
				word_code = {2'b00, x_reg};
				word_len = `LRC_PCM_LEN;
				word_kind = `LRC_KIND_PCM;
				store_en = 1'b1;
				cluster_next = 1'b1;
			end else if (moving) begin
				word_en = 1'b1;
				word_code = q_code;
				word_len = q_len;
				word_kind = `LRC_KIND_DPCM;
				store_en = 1'b1;
				store_val = rec;
			end else if (in_cluster_reg) begin
				word_en = 1'b1;
				word_code = `LRC_EOC_CODE;
				word_len = `LRC_EOC_LEN;
				word_kind = `LRC_KIND_EOC;
				cluster_next = 1'b0;
			end
			// a word that finds the output busy is dropped with its update
			if (word_en && !load_ok) begin
				store_en = 1'b0;
				cluster_next = 1'b0;
			end
			if (store_en)
				held_val = store_val;
			// the line's last cluster closes silently
			if (job_pix_reg == `LRC_LAST_PIX)
				cluster_next = 1'b0;
		end
	end

	// per-sample sequence: read stored, read above, code
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= ST_IDLE;
			x_reg <= `LRC_MID;
			s_reg <= `LRC_MID;
			job_pix_reg <= 8'h00;
			job_line_reg <= 8'h00;
			job_field_reg <= 1'b0;
			job_refresh_reg <= 1'b0;
			prev_rec_reg <= `LRC_MID;
			in_cluster_reg <= 1'b0;
		end else begin
			case (st_reg)
				ST_IDLE: begin
					if (start) begin
						x_reg <= lrc_clamp({2'b00, pair_sum[8:1]});
						job_pix_reg <= pix_reg[7:0];
						job_line_reg <= coded_line[7:0];
						job_field_reg <= field_reg;
						job_refresh_reg <= refresh_reg;
						st_reg <= ST_RDC;
					end
				end
				ST_RDC: begin
					st_reg <= ST_RDU;
				end
				ST_RDU: begin
					s_reg <= mem_q;
					st_reg <= ST_CODE;
				end
				ST_CODE: begin
					prev_rec_reg <= held_val;
					in_cluster_reg <= cluster_next;
					st_reg <= ST_IDLE;
				end
				default: begin
					st_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// output word register with ready back-pressure
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ov_valid_reg <= 1'b0;
			ov_code_reg <= 10'h000;
			ov_len_reg <= 4'h0;
			ov_kind_reg <= `LRC_KIND_PCM;
			ov_field_reg <= 1'b0;
			ov_line_reg <= 8'h00;
			ov_pix_reg <= 8'h00;
			overrun_reg <= 1'b0;
		end else begin
			overrun_reg <= word_en && !load_ok;
			if (word_en && load_ok) begin
				ov_valid_reg <= 1'b1;
				ov_code_reg <= word_code;
				ov_len_reg <= word_len;
				ov_kind_reg <= word_kind;
				ov_field_reg <= job_field_reg;
				ov_line_reg <= job_line_reg;
				ov_pix_reg <= job_pix_reg;
			end else if (out_ready) begin
				ov_valid_reg <= 1'b0;
			end
		end
	end

	// outputs
	assign out_valid = ov_valid_reg;
	assign out_code = ov_code_reg;
	assign out_len = ov_len_reg;
	assign out_kind = ov_kind_reg;
	assign out_field = ov_field_reg;
	assign out_line = ov_line_reg;
	assign out_pix = ov_pix_reg;
	assign out_overrun = overrun_reg;
endmodule // lrc_coder

// ### lrc_coder_sva.sv
`timescale 1ns/1ns
// word stream checks at the coder ports
module lrc_coder_sva (
	// clock, reset
	input wire ref_clk,
	input wire arst_n,
	// words
	input wire out_valid,
	input wire out_ready,
	input wire [9:0] out_code,
	input wire [3:0] out_len,
	input wire [1:0] out_kind,
	input wire [7:0] out_line,
	input wire [7:0] out_pix,
	input wire out_overrun
);
	reg open_reg;
	reg [7:0] pix_reg;
	// word classes and the word without its field for hold checks
	wire pcm = out_valid && (out_kind == 2'h0 || out_kind == 2'h3);
	wire eoc = out_valid && out_kind == 2'h2;
	wire dp = out_valid && out_kind == 2'h1;
	wire inner = out_valid && out_ready && (dp || eoc);
	wire [31:0] word_w = {out_code, out_len, out_kind, out_line, out_pix};
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_take;
		out_valid && out_ready;
	endsequence
	sequence s_stall;
		out_valid && !out_ready;
	endsequence
	// last taken word: cluster still open, and its pixel
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			open_reg <= 1'b0;
			pix_reg <= 8'h00;
		end else if (out_valid && out_ready) begin
			open_reg <= out_kind[1] == 1'b0;
			pix_reg <= out_pix;
		end
	end
	pcm_range_a: assert property (pcm |-> out_code >= 10'h010 && out_code <= 10'h0EF)
		else $error("pcm word outside black to white");
	pcm_width_a: assert property (pcm |-> out_len == 4'h8)
		else $error("pcm word not eight bits");
	eoc_code_a: assert property (eoc |-> out_code == 10'h009 && out_len == 4'h4)
		else $error("bad end of cluster word");
	vlc_len_a: assert property (dp |-> out_len >= 4'h2 && out_len <= 4'hA)
		else $error("dpcm length out of range");
	word_hold_a: assert property (s_stall |=> out_valid && $stable(word_w))
		else $error("stalled word changed");
	take_drop_a: assert property (s_take |=> !out_valid || !$stable(word_w))
		else $error("transferred word presented again");
	line_range_a: assert property (out_valid |-> out_line <= 8'h8E)
		else $error("coded line beyond last");
	drop_pulse_a: assert property (out_overrun |-> out_valid ##1 !out_overrun)
		else $error("overrun without full output");
	cluster_order_a: assert property (inner |-> open_reg && out_pix == pix_reg + 8'h01)
		else $error("cluster word out of order");
endmodule // lrc_coder_sva

bind lrc_coder lrc_coder_sva u_lrc_coder_sva (
	.ref_clk(ref_clk), .arst_n(arst_n), .out_valid(out_valid), .out_ready(out_ready),
	.out_code(out_code), .out_len(out_len), .out_kind(out_kind), .out_line(out_line),
	.out_pix(out_pix), .out_overrun(out_overrun)
);

// ### lrc_mux_sink.sv
`timescale 1ns/1ns
// multiplex stage: takes words, stalls on request, mirrors pcm samples by line and pixel
module lrc_mux_sink (
	// clock, reset
	input wire ref_clk,
	input wire arst_n,
	// stall request
	input wire stall,
	// words
	input wire out_valid,
	output wire out_ready,
	input wire [32:0] word
);
	logic [32:0] wq[$];
	logic [7:0] mirror [0:142][0:255];
	assign out_ready = !stall;
	// record each word; only addressed pcm words touch the mirror
	always @(posedge ref_clk) begin
		if (arst_n && out_valid && out_ready) begin
			wq.push_back(word);
			if (word[31:30] == 2'h0 || word[31:30] == 2'h3)
				mirror[word[15:8]][word[7:0]] = word[23:16];
		end
	end
endmodule // lrc_mux_sink

// ### luma_replenishment_coder_bench.sv
`timescale 1ns/1ns
// drives video lines into the coder and judges the coded words
module luma_replenishment_coder_bench;
	reg ref_clk = 1'b0;
	reg arst_n = 1'b0;
	reg [7:0] vid_data = 8'h00;
	reg vid_hsync = 1'b0;
	reg vid_vsync = 1'b0;
	reg vid_field = 1'b0;
	reg force_refresh = 1'b0;
	reg stall = 1'b0;
	wire out_valid, out_ready, out_field, out_overrun;
	wire [9:0] out_code;
	wire [3:0] out_len;
	wire [1:0] out_kind;
	wire [7:0] out_line, out_pix;
	integer bad_count = 0;
	integer samples_checked = 0;
	integer ovr_count = 0;
	integer frame = 0;
	logic [32:0] w;

	lrc_coder u_lrc_coder (.ref_clk(ref_clk), .arst_n(arst_n), .vid_data(vid_data),
		.vid_hsync(vid_hsync), .vid_vsync(vid_vsync), .vid_field(vid_field),
		.force_refresh(force_refresh), .out_valid(out_valid), .out_ready(out_ready),
		.out_code(out_code), .out_len(out_len), .out_kind(out_kind), .out_field(out_field),
		.out_line(out_line), .out_pix(out_pix), .out_overrun(out_overrun));
	lrc_mux_sink u_lrc_mux_sink (.ref_clk(ref_clk), .arst_n(arst_n), .stall(stall),
		.out_valid(out_valid), .out_ready(out_ready),
		.word({out_field, out_kind, out_len, out_code, out_line, out_pix}));

	// clock and overrun pulse counter
	always #5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (out_overrun === 1'b1) ovr_count = ovr_count + 1;

	task chk(input string what, input logic [32:0] got, input logic [32:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic [7:0] clip(input int i);
		return i < 16 ? 8'h10 : i > 239 ? 8'hEF : i[7:0];
	endfunction

	// frame 0 is a raw ramp; frame 1 moves three spots of the clipped ramp
	function automatic logic [7:0] pat(input int cl, input int i);
		if (frame == 0 || i > 255) return i[7:0];
		if (cl == 1 && i >= 10 && i <= 13) return clip(i) + 8'h3C;
		if (cl == 2 && i >= 100 && i <= 103) return clip(i) + 8'h28;
		if (cl == 2 && i >= 250) return i[7:0] - 8'h28;
		return clip(i);
	endfunction

	// one input line; pixel n is held around its sample tick
	task send_line(input int cl, input bit st);
		vid_data = pat(cl, 0);
		repeat (10) @(negedge ref_clk);
		vid_hsync = 1'b1;
		for (int n = 0; n < 320; n++) begin
			stall = st && n < 13;
			repeat (10) @(negedge ref_clk);
			vid_hsync = 1'b0;
			vid_data = pat(cl, n);
			repeat (10) @(negedge ref_clk);
		end
	endtask

	// one field of five input lines, giving coded lines 0 to 2
	task send_frame;
		vid_vsync = 1'b1;
		repeat (10) @(negedge ref_clk);
		vid_vsync = 1'b0;
		for (int l = 1; l < 6; l++)
			send_line(l / 2, frame == 1 && l == 3);
	endtask

	// next taken word of coded lines 1 and 2; line 0, paired with no sent line, is skipped
	task next_word;
		w = 33'h0_0000_0000;
		while (u_lrc_mux_sink.wq.size() > 0 && !(w[15:8] inside {8'h01, 8'h02}))
			w = u_lrc_mux_sink.wq.pop_front();
	endtask

	task exp_word(input logic [1:0] k, input logic [3:0] n, input logic [9:0] c,
		input logic [7:0] l, input logic [7:0] p, input bit full);
		next_word();
		if (!full) begin
			n = w[29:26];
			c = w[25:16];
		end
		chk("word", w, {1'b0, k, n, c, l, p});
	endtask

	// forced refresh: every sample of lines 1 and 2 as clipped pcm
	task sc_refresh;
		force_refresh = 1'b1;
		send_frame();
		force_refresh = 1'b0;
		for (int l = 1; l < 3; l++)
			for (int i = 0; i < 256; i++)
				exp_word(2'h3, 4'h8, {2'b00, clip(i)}, l[7:0], i[7:0], 1'b1);
		chk("mirror", u_lrc_mux_sink.mirror[2][200], clip(200));
	endtask

	// stalled cluster, plain cluster, and a cluster reaching the line end
	task sc_clusters;
		frame = 1;
		ovr_count = 0;
		send_frame();
		chk("overruns", ovr_count == 1, 1'b1);
		exp_word(2'h0, 4'h8, 10'h04C, 8'h01, 8'h0A, 1'b1);
		exp_word(2'h0, 4'h8, 10'h04C, 8'h01, 8'h0C, 1'b1);
		exp_word(2'h1, 4'h4, 10'h001, 8'h01, 8'h0D, 1'b1);
		exp_word(2'h2, 4'h4, 10'h009, 8'h01, 8'h0E, 1'b1);
		exp_word(2'h0, 4'h8, 10'h08C, 8'h02, 8'h64, 1'b1);
		for (int i = 101; i < 104; i++)
			exp_word(2'h1, 4'h4, 10'h001, 8'h02, i[7:0], 1'b1);
		exp_word(2'h2, 4'h4, 10'h009, 8'h02, 8'h68, 1'b1);
		exp_word(2'h0, 4'h8, 10'h0D2, 8'h02, 8'hFA, 1'b1);
		for (int i = 251; i < 255; i++)
			exp_word(2'h1, 4'h3, 10'h005, 8'h02, i[7:0], 1'b1);
		exp_word(2'h1, 4'h5, 10'h001, 8'h02, 8'hFF, 1'b1);
		next_word();
		chk("extra", w[15:8] inside {8'h01, 8'h02}, 1'b0);
	endtask

	// main sequence
	initial begin
		repeat (20) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (5) @(negedge ref_clk);
		sc_refresh();
		sc_clusters();
		end_sim();
	end

	// watchdog: both frames need about 64000 cycles
	initial begin
		repeat (90000) @(posedge ref_clk);
		bad_count = bad_count + 1;
		end_sim();
	end
endmodule // luma_replenishment_coder_bench
